// ### rsc_pkg.sv
/*
 * rsc_pkg: constants and carrier types for the reset source controller.
 * assumes a single 25 MHz system clock; no software-visible registers.
 */
package rsc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int RSC_CLK_PERIOD_NS = 40;
  localparam int RSC_PIN_MIN_WIDTH_NS = 10000;
  localparam int RSC_PIN_MIN_CYC = (RSC_PIN_MIN_WIDTH_NS + RSC_CLK_PERIOD_NS - 1) /
                                   RSC_CLK_PERIOD_NS;
  localparam int RSC_PROC_CYC = 16;
  localparam int RSC_STAB_CYC = 64;
  localparam int RSC_CNT_W = 8;

  // ****************************************************************
  // reset values and codes
  // ****************************************************************
  localparam logic [19:0] RSC_RESET_VECTOR_ADDR = 20'h00000;
  localparam logic [7:0] RSC_ILLEGAL_OPCODE = 8'hFF;
  localparam int RSC_LVD_ON_BIT = 7;
  localparam int RSC_PORT_W = 8;
  localparam logic [RSC_PORT_W-1:0] RSC_PORT_LOW_MASK = 8'h01;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic pin;
    logic wdt;
    logic power_on_clear;
    logic lvd;
    logic illegal;
    logic check_err;
  } rsc_causes_t;

  typedef struct packed {
    logic x1_en;
    logic xt1_en;
    logic hoco_en;
    logic loco_en;
    logic ext_clk_valid;
  } rsc_osc_t;

  typedef enum logic [1:0] {
    RSC_ST_RESET,
    RSC_ST_PROC,
    RSC_ST_STAB,
    RSC_ST_RUN
  } rsc_state_t;

endpackage

// ### rsc_reset_source_controller.sv
/*
 * rsc_reset_source_controller: merges reset causes into one system reset,
 * sequences release, parks the pins and restarts from the reset vector.
 * assumes detector levels are asynchronous, cpu/debug strobes are on SYS_CLK.
 */
// Contract
// - merge six reset causes into one reset
// - restart fetch from vector at lowest addresses
// - pins high impedance, one pin drives low
// - hold reset while pin low, then run
// - watchdog reset releases itself automatically
// - hold supply reset until detector recovers
// - illegal opcode execution raises internal reset
// - no illegal opcode reset under debug
// - stop oscillators, ignore external clock in reset; hoco_en is already on during the stabilisation wait while SYS_RESET is high
// - keep ram contents through reset from stop
// - return special registers to initial values
// - set detector enable bit on restart
`timescale 1ns/10ps
module rsc_reset_source_controller
  import rsc_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // reset causes
  input wire logic RESET_PIN_N,
  input wire logic WDT_OVERFLOW,
  input wire logic POWER_ON_CLEAR_LOW,
  input wire logic LVD_LOW,
  input wire logic CHECK_ERROR,
  // cpu side
  input wire logic OPCODE_VALID,
  input wire logic [7:0] OPCODE,
  input wire logic DEBUG_EMULATION,
  input wire logic LVD_ON_CLEAR,
  input wire logic IN_STOP_MODE,
  // outputs
  output logic SYS_RESET,
  output logic CPU_START,
  output logic [19:0] CPU_FETCH_ADDR,
  output rsc_osc_t OSC_CTRL,
  output logic [RSC_PORT_W-1:0] PORT_OE,
  output logic [RSC_PORT_W-1:0] PORT_OUT,
  output logic SFR_INIT,
  output logic RAM_RETAIN,
  output logic LOW_VOLTAGE_DETECT_ON,
  output rsc_causes_t LAST_CAUSE
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {~RESET_PIN_N, WDT_OVERFLOW, POWER_ON_CLEAR_LOW, LVD_LOW};
      sync2 <= sync1;
    end
  end

  // ****************************************************************
  // cause merge
  // ****************************************************************
  rsc_causes_t cause;
  logic any_cause;
  logic hold_cause;
  always_comb begin
    cause.pin = sync2[3];
    cause.wdt = sync2[2];
    cause.power_on_clear = sync2[1];
    cause.lvd = sync2[0];
    cause.illegal = OPCODE_VALID && (OPCODE == RSC_ILLEGAL_OPCODE)
                    && !DEBUG_EMULATION;
    cause.check_err = CHECK_ERROR;
    any_cause = |cause;
    // levels that keep reset held; pulses only start it
    hold_cause = cause.pin || cause.power_on_clear || cause.lvd;
  end

  // ****************************************************************
  // release sequencer
  // ****************************************************************
  rsc_state_t state;
  rsc_state_t next_state;
  logic [RSC_CNT_W-1:0] cnt;
  logic [RSC_CNT_W-1:0] next_cnt;
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (any_cause) begin
      next_state = RSC_ST_RESET;
      next_cnt = '0;
    end else begin
      unique case (state)
        RSC_ST_RESET: begin
          if (!hold_cause) begin
            next_state = RSC_ST_PROC;
            next_cnt = '0;
          end
        end
        RSC_ST_PROC: begin
          if (cnt == RSC_CNT_W'(RSC_PROC_CYC - 1)) begin
            next_state = RSC_ST_STAB;
            next_cnt = '0;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
        RSC_ST_STAB: begin
          if (cnt == RSC_CNT_W'(RSC_STAB_CYC - 1)) begin
            next_state = RSC_ST_RUN;
            next_cnt = '0;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
        RSC_ST_RUN: begin
          next_cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state <= RSC_ST_RESET;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic next_sys_reset;
  logic next_cpu_start;
  rsc_osc_t next_osc;
  logic next_ram_retain;
  logic next_lvd_on;
  rsc_causes_t next_last;
  logic in_reset;
  always_comb begin
    in_reset = (next_state != RSC_ST_RUN);
    next_sys_reset = in_reset;
    next_cpu_start = (state == RSC_ST_STAB) && (next_state == RSC_ST_RUN);
    // only the internal high-speed oscillator restarts; the rest wait for software
    next_osc.x1_en = 1'b0;
    next_osc.xt1_en = 1'b0;
    next_osc.loco_en = 1'b0;
    next_osc.ext_clk_valid = 1'b0;
    next_osc.hoco_en = (next_state == RSC_ST_STAB) || (next_state == RSC_ST_RUN);
    // ram is never cleared here; retain flags a stop-mode wake in progress
    next_ram_retain = RAM_RETAIN ? in_reset : (IN_STOP_MODE && any_cause);
    next_lvd_on = LOW_VOLTAGE_DETECT_ON;
    if (next_cpu_start) begin
      next_lvd_on = 1'b1;
    end else if (LVD_ON_CLEAR && !in_reset) begin
      next_lvd_on = 1'b0;
    end
    next_last = any_cause ? (LAST_CAUSE | cause) : LAST_CAUSE;
    if (next_cpu_start) begin
      next_last = LAST_CAUSE;
    end else if (any_cause && (state == RSC_ST_RUN)) begin
      next_last = cause;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      SYS_RESET <= 1'b1;
      CPU_START <= 1'b0;
      CPU_FETCH_ADDR <= RSC_RESET_VECTOR_ADDR;
      OSC_CTRL <= '0;
      PORT_OE <= RSC_PORT_LOW_MASK;
      PORT_OUT <= '0;
      SFR_INIT <= 1'b1;
      RAM_RETAIN <= 1'b0;
      LOW_VOLTAGE_DETECT_ON <= 1'b1;
      LAST_CAUSE <= '0;
    end else begin
      SYS_RESET <= next_sys_reset;
      CPU_START <= next_cpu_start;
      CPU_FETCH_ADDR <= RSC_RESET_VECTOR_ADDR;
      OSC_CTRL <= next_osc;
      PORT_OE <= RSC_PORT_LOW_MASK;
      PORT_OUT <= '0;
      SFR_INIT <= next_sys_reset;
      RAM_RETAIN <= next_ram_retain;
      LOW_VOLTAGE_DETECT_ON <= next_lvd_on;
      LAST_CAUSE <= next_last;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_release;
    (state == RSC_ST_STAB) ##1 (state == RSC_ST_RUN);
  endsequence

  a_illegal_resets: assert property (@(posedge SYS_CLK) disable iff (RST)
    (OPCODE_VALID && OPCODE == RSC_ILLEGAL_OPCODE && !DEBUG_EMULATION) |=> SYS_RESET)
    else $error("illegal opcode did not reset");
  a_debug_suppress: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state == RSC_ST_RUN && !hold_cause && !cause.wdt && !CHECK_ERROR
     && OPCODE_VALID && DEBUG_EMULATION) |=> !SYS_RESET)
    else $error("reset under debug emulation");
  a_pin_holds: assert property (@(posedge SYS_CLK) disable iff (RST)
    sync2[3] |=> (state == RSC_ST_RESET) && SYS_RESET)
    else $error("reset not held while pin low");
  a_wdt_release: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cause.wdt ##1 !any_cause [*8]) |-> (state != RSC_ST_RESET))
    else $error("watchdog reset did not release");
  a_supply_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
    (sync2[1] || sync2[0]) |=> state == RSC_ST_RESET)
    else $error("supply reset released early");
  a_vector_start: assert property (@(posedge SYS_CLK) disable iff (RST)
    s_release |-> CPU_START && CPU_FETCH_ADDR == RSC_RESET_VECTOR_ADDR && !SYS_RESET)
    else $error("start not from reset vector");
  a_pins_parked: assert property (@(posedge SYS_CLK) disable iff (RST)
    SYS_RESET |-> PORT_OE == RSC_PORT_LOW_MASK && PORT_OUT == '0)
    else $error("pins not parked in reset");
  a_osc_stopped: assert property (@(posedge SYS_CLK) disable iff (RST)
    $rose(SYS_RESET) |-> !OSC_CTRL.x1_en && !OSC_CTRL.hoco_en && !OSC_CTRL.ext_clk_valid)
    else $error("oscillators running in reset");
  a_lvd_reenable: assert property (@(posedge SYS_CLK) disable iff (RST)
    s_release |-> LOW_VOLTAGE_DETECT_ON)
    else $error("detector enable not set on restart");
  a_sfr_init: assert property (@(posedge SYS_CLK) disable iff (RST)
    SFR_INIT == SYS_RESET)
    else $error("sfr init out of step with reset");
  a_ram_retain: assert property (@(posedge SYS_CLK) disable iff (RST)
    (IN_STOP_MODE && any_cause) |=> RAM_RETAIN)
    else $error("ram retention lost in stop reset");
  a_one_edge: assert property (@(posedge SYS_CLK) disable iff (RST)
    $fell(SYS_RESET) |-> CPU_START && $past(state) == RSC_ST_STAB)
    else $error("release not on one edge");

endmodule

// ### rsc_supply_model.sv
/*
 * rsc_supply_model: external reset pin driver and supply supervisors.
 * assumes commands come from the bench just after a rising clock edge.
 */
`timescale 1ns/10ps
module rsc_supply_model
  import rsc_pkg::*;
#(
  parameter int HOLD_CYC = RSC_PIN_MIN_CYC
) (
  // clock
  input wire logic clk,
  // command: 1 pin, 2 power-on clear, 3 supply drop
  input wire logic go,
  input wire logic [1:0] cmd,
  // lines to the device
  output logic reset_pin_n,
  output logic power_on_clear_low,
  output logic lvd_low,
  output logic busy
);
  // ****
  // hold logic
  // ****
  int cnt = 0;
  logic [1:0] src = 2'h0;
  // pin has a pull-up; detectors read low-inactive once supply is back
  always_comb begin
    busy = (cnt != 0);
    reset_pin_n = !(busy && src == 2'h1);
    power_on_clear_low = busy && src == 2'h2;
    lvd_low = busy && src == 2'h3;
  end
  always @(posedge clk) begin
    if (go && !busy) begin
      src <= cmd;
      cnt <= HOLD_CYC; // never shorter than the minimum width
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ### testbench.sv
/*
 * testbench: table walk over every reset cause, then reset and restart cases.
 * assumes the supply model stands in for the pin driver and detectors.
 */
`timescale 1ns/10ps
module testbench
  import rsc_pkg::*;
;
  typedef struct packed {
    logic [2:0] kind;
    logic stop;
    logic dbg;
    logic rst;
    logic [5:0] cause;
  } rsc_row_t;
  localparam int SEQ = RSC_PROC_CYC + RSC_STAB_CYC;
  logic SYS_CLK, RST, RESET_PIN_N, WDT_OVERFLOW, POWER_ON_CLEAR_LOW, LVD_LOW, CHECK_ERROR;
  logic OPCODE_VALID, DEBUG_EMULATION, LVD_ON_CLEAR, IN_STOP_MODE, SYS_RESET, CPU_START;
  logic SFR_INIT, RAM_RETAIN, LOW_VOLTAGE_DETECT_ON, go, busy;
  logic [7:0] OPCODE, PORT_OE, PORT_OUT;
  logic [19:0] CPU_FETCH_ADDR;
  logic [1:0] cmd;
  rsc_osc_t OSC_CTRL;
  rsc_causes_t LAST_CAUSE;
  int n_fail = 0;
  int samples_checked = 0;
  int i;
  rsc_row_t rows [8];

  rsc_reset_source_controller u_rsc_reset_source_controller (
    .SYS_CLK(SYS_CLK), .RST(RST), .RESET_PIN_N(RESET_PIN_N), .WDT_OVERFLOW(WDT_OVERFLOW),
    .POWER_ON_CLEAR_LOW(POWER_ON_CLEAR_LOW), .LVD_LOW(LVD_LOW), .CHECK_ERROR(CHECK_ERROR),
    .OPCODE_VALID(OPCODE_VALID), .OPCODE(OPCODE), .DEBUG_EMULATION(DEBUG_EMULATION),
    .LVD_ON_CLEAR(LVD_ON_CLEAR), .IN_STOP_MODE(IN_STOP_MODE), .SYS_RESET(SYS_RESET),
    .CPU_START(CPU_START), .CPU_FETCH_ADDR(CPU_FETCH_ADDR), .OSC_CTRL(OSC_CTRL),
    .PORT_OE(PORT_OE), .PORT_OUT(PORT_OUT), .SFR_INIT(SFR_INIT), .RAM_RETAIN(RAM_RETAIN),
    .LOW_VOLTAGE_DETECT_ON(LOW_VOLTAGE_DETECT_ON), .LAST_CAUSE(LAST_CAUSE));
  rsc_supply_model u_rsc_supply_model (.clk(SYS_CLK), .go(go), .cmd(cmd),
    .reset_pin_n(RESET_PIN_N), .power_on_clear_low(POWER_ON_CLEAR_LOW), .lvd_low(LVD_LOW),
    .busy(busy));

  // ****
  // tasks
  // ****
  task automatic tick(input int n = 1);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_reset();
    chk("sys reset", 20'h1, 20'(SYS_RESET));
    chk("sfr init", 20'h1, 20'(SFR_INIT));
    chk("osc", 20'h0, 20'(OSC_CTRL));
    chk("port oe", 20'(RSC_PORT_LOW_MASK), 20'(PORT_OE));
    chk("port out", 20'h0, 20'(PORT_OUT));
  endtask
  // bounded, so a start that never comes shows as a mismatch
  task automatic wait_start(output int n);
    n = 0;
    while (CPU_START !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    chk("start", 20'h1, 20'(CPU_START));
    chk("fetch", RSC_RESET_VECTOR_ADDR, CPU_FETCH_ADDR);
    chk("osc run", 20'h4, 20'(OSC_CTRL));
    chk("lvd on", 20'h1, 20'(LOW_VOLTAGE_DETECT_ON));
  endtask
  task automatic apply(input logic [2:0] kind);
    cmd = (kind[1:0] == 2'h0) ? 2'h1 : kind[1:0];
    case (kind)
      3'h1: WDT_OVERFLOW = 1;
      3'h4: OPCODE_VALID = 1;
      3'h5: CHECK_ERROR = 1;
      3'h6: begin
        OPCODE = 8'hFE;
        OPCODE_VALID = 1;
      end
      default: go = 1;
    endcase
    tick();
    WDT_OVERFLOW = 0;
    OPCODE_VALID = 0;
    CHECK_ERROR = 0;
    OPCODE = RSC_ILLEGAL_OPCODE;
    go = 0;
  endtask

  initial begin
    SYS_CLK = 0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    tick(20000);
    n_fail++;
    stop_test();
  end
  initial begin
    RST = 1;
    WDT_OVERFLOW = 0;
    CHECK_ERROR = 0;
    OPCODE_VALID = 0;
    OPCODE = RSC_ILLEGAL_OPCODE;
    DEBUG_EMULATION = 0;
    LVD_ON_CLEAR = 0;
    IN_STOP_MODE = 0;
    go = 0;
    cmd = 2'h0;
    rows = '{'{3'h0, 1'b0, 1'b0, 1'b1, 6'h20}, '{3'h1, 1'b1, 1'b0, 1'b1, 6'h10},
             '{3'h2, 1'b0, 1'b0, 1'b1, 6'h08}, '{3'h3, 1'b0, 1'b0, 1'b1, 6'h04},
             '{3'h4, 1'b0, 1'b0, 1'b1, 6'h02}, '{3'h5, 1'b0, 1'b0, 1'b1, 6'h01},
             '{3'h4, 1'b0, 1'b1, 1'b0, 6'h00}, '{3'h6, 1'b0, 1'b0, 1'b0, 6'h00}};
    tick(8);
    chk_reset();
    RST = 0;
    wait_start(i);
    foreach (rows[r]) begin
      LVD_ON_CLEAR = 1;
      tick();
      LVD_ON_CLEAR = 0;
      tick();
      chk("lvd off", 20'h0, 20'(LOW_VOLTAGE_DETECT_ON));
      IN_STOP_MODE = rows[r].stop;
      DEBUG_EMULATION = rows[r].dbg;
      apply(rows[r].kind);
      for (i = 0; i < 8 && SYS_RESET !== 1'b1; i++) tick();
      chk("cause", 20'(rows[r].rst), 20'(SYS_RESET));
      if (rows[r].rst) begin
        tick();
        chk_reset();
        chk("ram keep", 20'(rows[r].stop), 20'(RAM_RETAIN));
        for (i = 0; i < 300 && busy === 1'b1; i++) tick();
        wait_start(i);
        chk("hold", 20'h1, 20'(i >= SEQ - 2 && i <= SEQ + 8));
        chk("which", 20'(rows[r].cause), 20'(LAST_CAUSE));
      end
      IN_STOP_MODE = 0;
      DEBUG_EMULATION = 0;
      tick();
    end
    WDT_OVERFLOW = 1;
    tick(30);
    RST = 1;
    WDT_OVERFLOW = 0;
    tick();
    chk_reset();
    chk("cause clr", 20'h0, 20'(LAST_CAUSE));
    chk("lvd rst", 20'h1, 20'(LOW_VOLTAGE_DETECT_ON));
    chk("no start", 20'h0, 20'(CPU_START));
    RST = 0;
    // a software clear during the release sequence must not stick
    LVD_ON_CLEAR = 1;
    tick();
    LVD_ON_CLEAR = 0;
    chk("lvd hold", 20'h1, 20'(LOW_VOLTAGE_DETECT_ON));
    wait_start(i);
    chk("seq", 20'h1, 20'(i + 1 >= SEQ && i + 1 <= SEQ + 8));
    stop_test();
  end
endmodule
